// ==== dma_hub.sv ====
// dma hub: descriptor engine, channel arbiter and spoke access
//
// Our own choices: the APB register port and the placing of the registers.
module dma_hub (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb register slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dma_hub_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// channel triggers from routed signals
	input wire logic [dma_hub_pkg::NUM_CH-1:0] trig_in,
	// processor access to the spokes
	input wire logic cpu_req,
	input wire logic [2:0] cpu_spoke,
	output logic cpu_gnt,
	// dma source side
	output logic rd_req,
	output logic [31:0] rd_addr,
	output logic [1:0] rd_size,
	input wire logic [31:0] rd_data,
	// dma destination side
	output logic wr_req,
	output logic [31:0] wr_addr,
	output logic [1:0] wr_size,
	output logic [31:0] wr_data,
	// per channel completion pulses
	output logic [dma_hub_pkg::NUM_CH-1:0] term0,
	output logic [dma_hub_pkg::NUM_CH-1:0] term1
);
	//==========================================================================
	// state
	typedef struct packed {
		dma_hub_pkg::fsm_t st;
		logic fair_en;
		logic [dma_hub_pkg::NUM_CH-1:0] pend;
		logic [dma_hub_pkg::NUM_CH-1:0] cancel; // cancel of active channel
		dma_hub_pkg::cfg_t [dma_hub_pkg::NUM_CH-1:0] cfg;
		dma_hub_pkg::ctx_t [dma_hub_pkg::NUM_CH-1:0] ctx;
		logic [dma_hub_pkg::NUM_LVL-1:0][dma_hub_pkg::CH_W-1:0] rr;
		logic [dma_hub_pkg::SLOT_W-1:0] slot;
		logic [3:0] starve;
		logic [dma_hub_pkg::CH_W-1:0] ch; // active channel
		logic [31:0] src;
		logic [31:0] dst;
		dma_hub_pkg::td_ctl_t ctl;
		logic [16:0] rem;
		logic [15:0] off;
		logic [2:0] beats;
		logic last; // last read of the descriptor issued
		logic rd_req;
		logic [31:0] rd_addr;
		logic [1:0] rd_size;
		logic rd_fly; // read data arrives this cycle
		logic [31:0] wa0;
		logic [31:0] wa1;
		logic wb_v; // write waiting for its spoke
		logic [31:0] wb_addr;
		logic [31:0] wb_data;
		logic [1:0] wb_size;
		logic wr_req;
		logic [31:0] wr_addr;
		logic [1:0] wr_size;
		logic [31:0] wr_data;
		logic cpu_gnt;
		logic [dma_hub_pkg::NUM_CH-1:0] term0;
		logic [dma_hub_pkg::NUM_CH-1:0] term1;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} hub_state_t;

	hub_state_t q; // registered state
	hub_state_t n; // next state

	// descriptor pool; kept out of the state word since it needs no reset
	logic [31:0] td_src [dma_hub_pkg::NUM_TD];
	logic [31:0] td_dst [dma_hub_pkg::NUM_TD];
	dma_hub_pkg::td_ctl_t td_ctl [dma_hub_pkg::NUM_TD];

	//==========================================================================
	// address decode
	logic setup; // apb setup cycle
	logic acc; // apb access edge
	logic [dma_hub_pkg::CH_W-1:0] ch_idx;
	logic [dma_hub_pkg::TD_W-1:0] td_idx;
	logic [1:0] td_word;
	logic ch_hit;
	logic td_hit;
	logic reg_hit;

	assign setup = psel & ~penable;
	assign acc = psel & penable & q.pready;
	assign ch_idx = paddr[dma_hub_pkg::CH_IDX_HI:dma_hub_pkg::CH_IDX_LO];
	assign td_idx = paddr[dma_hub_pkg::TD_IDX_HI:dma_hub_pkg::TD_IDX_LO];
	assign td_word = paddr[dma_hub_pkg::WORD_HI:dma_hub_pkg::WORD_LO];
	assign ch_hit = (paddr[dma_hub_pkg::ADDR_W-1:dma_hub_pkg::CH_IDX_HI+1]
		== dma_hub_pkg::CH_BASE[dma_hub_pkg::ADDR_W-1:dma_hub_pkg::CH_IDX_HI+1])
		&& (int'(ch_idx) < dma_hub_pkg::NUM_CH);
	assign td_hit = paddr >= dma_hub_pkg::TD_BASE;
	assign reg_hit = (paddr == dma_hub_pkg::REG_CTRL)
		|| (paddr == dma_hub_pkg::REG_STATUS)
		|| (paddr == dma_hub_pkg::REG_PEND) || (paddr == dma_hub_pkg::REG_CMD);

	// spoke of an address
	function automatic logic [2:0] spoke_of(input logic [31:0] a);
		return a[dma_hub_pkg::SPOKE_HI:dma_hub_pkg::SPOKE_LO];
	endfunction : spoke_of

	//==========================================================================
	// descriptor pool writes; software may rewrite a live chain
	always_ff @(posedge clk) begin
		if (acc && pwrite && td_hit) begin
			unique case (td_word)
				dma_hub_pkg::TD_WORD_SRC: td_src[td_idx] <= pwdata;
				dma_hub_pkg::TD_WORD_DST: td_dst[td_idx] <= pwdata;
				dma_hub_pkg::TD_WORD_CTL: td_ctl[td_idx] <= pwdata;
				default: ; // fourth word is not stored
			endcase
		end
	end

	//==========================================================================
	// next state
	always_comb begin
		logic [dma_hub_pkg::NUM_CH-1:0] elig;
		logic [dma_hub_pkg::NUM_CH-1:0] cand;
		logic [dma_hub_pkg::NUM_CH-1:0] set_p;
		logic [dma_hub_pkg::NUM_LVL-1:0] lvl_req;
		logic [2:0] lvl;
		logic [2:0] fav;
		logic fav_ok;
		logic found;
		logic [dma_hub_pkg::CH_W-1:0] sel;
		logic [31:0] rd_a;
		logic [16:0] w;
		logic dma_first;
		logic wr_conf;
		logic rd_conf;
		logic go_wr;
		logic want_rd;
		logic go_rd;
		logic stop;
		dma_hub_pkg::cmd_t cmd;
		dma_hub_pkg::td_ctl_t tc;
		int k;
		elig = '0;
		cand = '0;
		set_p = '0;
		lvl_req = '0;
		lvl = '0;
		fav = '0;
		fav_ok = 1'b0;
		found = 1'b0;
		sel = '0;
		cmd = pwdata;
		tc = td_ctl[q.ctx[q.ch].td];
		k = 0;
		n = q;
		// pulses default low
		n.term0 = '0;
		n.term1 = '0;
		n.rd_req = 1'b0;
		n.wr_req = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.rd_fly = q.rd_req;
		n.wa1 = q.wa0;

		// ---- spoke access: cpu first, dma wins after too long a wait
		rd_a = q.src + 32'(q.off);
		w = 17'(q.ctl.size) + 17'h0_0001;
		stop = q.cancel[q.ch] | q.cfg[q.ch].stall;
		dma_first = (q.starve == dma_hub_pkg::STARVE_LIMIT);
		wr_conf = q.wb_v & cpu_req & (spoke_of(q.wb_addr) == cpu_spoke);
		go_wr = q.wb_v & (~wr_conf | dma_first);
		want_rd = (q.st == dma_hub_pkg::ST_RUN) & ~q.last & ~stop
			& (q.beats != dma_hub_pkg::BURST_BEATS) & ~q.rd_req & ~q.rd_fly
			& (~q.wb_v | go_wr);
		rd_conf = cpu_req & (spoke_of(rd_a) == cpu_spoke);
		// a read beside a write only when they sit on different spokes
		go_rd = want_rd & (~rd_conf | dma_first)
			& ~(go_wr & (spoke_of(rd_a) == spoke_of(q.wb_addr)));
		// cpu keeps its spoke unless dma has been held off too long
		n.cpu_gnt = cpu_req & ~(dma_first
			& ((go_wr & wr_conf) | (go_rd & rd_conf)));
		if ((q.wb_v & ~go_wr) | (want_rd & ~go_rd)) begin
			if (q.starve != dma_hub_pkg::STARVE_LIMIT) begin
				n.starve = q.starve + 4'h1;
			end
		end else begin
			n.starve = '0;
		end

		// ---- destination write from the holding buffer
		if (go_wr) begin
			n.wr_req = 1'b1;
			n.wr_addr = q.wb_addr;
			n.wr_data = q.wb_data;
			n.wr_size = q.wb_size;
			n.wb_v = 1'b0;
		end
		// read data lands in the buffer one cycle after the read
		if (q.rd_fly) begin
			n.wb_v = 1'b1;
			n.wb_addr = q.wa1;
			n.wb_data = rd_data;
			n.wb_size = q.rd_size;
		end

		// ---- transfer engine
		unique case (q.st)
			dma_hub_pkg::ST_IDLE: begin
				// eligible channels and the levels that hold them
				elig = q.pend;
				for (int i = 0; i < dma_hub_pkg::NUM_CH; i++) begin
					elig[i] = q.pend[i] & q.cfg[i].en & ~q.cfg[i].stall;
					if (elig[i]) begin
						lvl_req[q.cfg[i].prio] = 1'b1;
					end
				end
				// plain priority: lowest level number with a request
				for (int l = dma_hub_pkg::NUM_LVL - 1; l >= 0; l--) begin
					if (lvl_req[l]) begin
						lvl = 3'(l);
					end
				end
				// slot of the weighted schedule: lowest set bit picks level
				for (int b = dma_hub_pkg::SLOT_W - 2; b >= 0; b--) begin
					if (q.slot[b]) begin
						fav = 3'(dma_hub_pkg::LVL_FAIR_MIN + b);
						fav_ok = 1'b1;
					end
				end
				// levels 0 and 1 stay outside the weighted slots
				if (q.fair_en && int'(lvl) >= dma_hub_pkg::LVL_FAIR_MIN
					&& fav_ok && lvl_req[fav]) begin
					lvl = fav;
				end
				for (int i = 0; i < dma_hub_pkg::NUM_CH; i++) begin
					cand[i] = elig[i] & (q.cfg[i].prio == lvl);
				end
				// head of the line for channels outside round robin
				for (int i = 0; i < dma_hub_pkg::NUM_CH; i++) begin
					if (!found && cand[i] && q.cfg[i].rr_dis) begin
						sel = dma_hub_pkg::CH_W'(i);
						found = 1'b1;
					end
				end
				// otherwise the next channel after the level's pointer
				for (int j = 1; j <= dma_hub_pkg::NUM_CH; j++) begin
					k = int'(q.rr[lvl]) + j;
					if (k >= dma_hub_pkg::NUM_CH) begin
						k = k - dma_hub_pkg::NUM_CH;
					end
					if (!found && cand[k]) begin
						sel = dma_hub_pkg::CH_W'(k);
						found = 1'b1;
					end
				end
				if (found) begin
					n.ch = sel;
					n.rr[lvl] = sel;
					if (q.fair_en && int'(lvl) >= dma_hub_pkg::LVL_FAIR_MIN) begin
						n.slot = q.slot + dma_hub_pkg::SLOT_W'(1);
					end
					n.st = dma_hub_pkg::ST_LOAD;
				end
			end
			dma_hub_pkg::ST_LOAD: begin
				// base addresses reread each burst so edits take hold
				n.src = td_src[q.ctx[q.ch].td];
				n.dst = td_dst[q.ctx[q.ch].td];
				n.ctl = tc;
				n.beats = '0;
				n.last = 1'b0;
				if (q.ctx[q.ch].rem == '0) begin
					n.rem = 17'(tc.len) + 17'h0_0001;
					n.off = '0;
				end else begin
					n.rem = q.ctx[q.ch].rem;
					n.off = q.ctx[q.ch].off;
				end
				n.st = dma_hub_pkg::ST_RUN;
			end
			dma_hub_pkg::ST_RUN: begin
				if (go_rd) begin
					n.rd_req = 1'b1;
					n.rd_addr = rd_a;
					n.rd_size = q.ctl.size;
					n.wa0 = q.dst + 32'(q.off);
					n.off = q.off + w[15:0];
					n.beats = q.beats + 3'h1;
					// unbounded descriptors never end by count
					if (!q.ctl.inf && q.rem <= w) begin
						n.last = 1'b1;
					end else if (!q.ctl.inf) begin
						n.rem = q.rem - w;
					end
				end else if (!want_rd && !q.rd_req && !q.rd_fly && !q.wb_v) begin
					// burst drained; a pre-empting channel may now win
					n.st = dma_hub_pkg::ST_DONE;
				end
			end
			dma_hub_pkg::ST_DONE: begin
				n.st = dma_hub_pkg::ST_IDLE;
				if (q.cancel[q.ch]) begin
					// cancel drops the rest of the chain
					n.cancel[q.ch] = 1'b0;
					n.pend[q.ch] = 1'b0;
					n.ctx[q.ch].td = q.cfg[q.ch].first_td;
					n.ctx[q.ch].rem = '0;
				end else if (q.last) begin
					n.term0[q.ch] = q.ctl.t0_en;
					n.ctx[q.ch].rem = '0;
					if (q.ctl.chain_end) begin
						n.pend[q.ch] = 1'b0;
						n.term1[q.ch] = q.ctl.t1_en;
						n.ctx[q.ch].td = q.cfg[q.ch].first_td;
						if (q.cfg[q.ch].chain_en) begin
							set_p[q.cfg[q.ch].chain_ch] = 1'b1;
						end
					end else begin
						// self link repeats, pairs ping pong, rings circle
						n.ctx[q.ch].td = q.ctl.next;
					end
				end else begin
					// pre-empted or stalled: keep the place for later
					n.ctx[q.ch].rem = q.rem;
					n.ctx[q.ch].off = q.off;
				end
			end
		endcase

		// ---- apb register writes
		if (acc && pwrite) begin
			if (paddr == dma_hub_pkg::REG_CTRL) begin
				n.fair_en = pwdata[dma_hub_pkg::CTRL_FAIR_BIT];
			end else if (paddr == dma_hub_pkg::REG_CMD
				&& int'(cmd.ch) < dma_hub_pkg::NUM_CH) begin
				if (cmd.op == dma_hub_pkg::CMD_TRIG) begin
					set_p[cmd.ch] = 1'b1;
				end else if (cmd.op == dma_hub_pkg::CMD_CANCEL) begin
					if (n.st != dma_hub_pkg::ST_IDLE && n.ch == cmd.ch) begin
						n.cancel[cmd.ch] = 1'b1;
					end else begin
						n.pend[cmd.ch] = 1'b0;
						n.ctx[cmd.ch].td = q.cfg[cmd.ch].first_td;
						n.ctx[cmd.ch].rem = '0;
					end
				end
			end else if (ch_hit) begin
				// a new setup also rewinds the channel to its first descriptor
				n.cfg[ch_idx] = pwdata[dma_hub_pkg::CFG_W-1:0];
				n.ctx[ch_idx].td = pwdata[dma_hub_pkg::TD_W-1:0];
				n.ctx[ch_idx].rem = '0;
			end
		end
		// triggers are applied last so a set beats a same-cycle clear
		n.pend = n.pend | set_p | trig_in;

		// ---- apb answer: one wait-free access cycle after setup
		if (setup) begin
			n.pready = 1'b1;
			n.pslverr = ~(reg_hit | ch_hit | td_hit);
			n.prdata = '0;
			if (paddr == dma_hub_pkg::REG_CTRL) begin
				n.prdata[dma_hub_pkg::CTRL_FAIR_BIT] = q.fair_en;
			end else if (paddr == dma_hub_pkg::REG_STATUS) begin
				n.prdata = (32'(q.ch) << dma_hub_pkg::STAT_CH_LO)
					| 32'(q.st != dma_hub_pkg::ST_IDLE);
			end else if (paddr == dma_hub_pkg::REG_PEND) begin
				n.prdata = 32'(q.pend);
			end else if (ch_hit) begin
				n.prdata = 32'(q.cfg[ch_idx]);
			end else if (td_hit) begin
				unique case (td_word)
					dma_hub_pkg::TD_WORD_SRC: n.prdata = td_src[td_idx];
					dma_hub_pkg::TD_WORD_DST: n.prdata = td_dst[td_idx];
					dma_hub_pkg::TD_WORD_CTL: n.prdata = td_ctl[td_idx];
					default: n.prdata = '0;
				endcase
			end
		end
	end

	//==========================================================================
	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	//==========================================================================
	// outputs straight from the state register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign cpu_gnt = q.cpu_gnt;
	assign rd_req = q.rd_req;
	assign rd_addr = q.rd_addr;
	assign rd_size = q.rd_size;
	assign wr_req = q.wr_req;
	assign wr_addr = q.wr_addr;
	assign wr_size = q.wr_size;
	assign wr_data = q.wr_data;
	assign term0 = q.term0;
	assign term1 = q.term1;
endmodule : dma_hub

// ==== dma_hub_pkg.sv ====
// constants, types and register map of the dma hub and its arbiter
//==============================================================================
package dma_hub_pkg;
	//==========================================================================
	// sizes
	localparam int NUM_CH = 24;
	localparam int NUM_TD = 128;
	localparam int NUM_LVL = 8;
	localparam int CH_W = 5;
	localparam int TD_W = 7;
	localparam int ADDR_W = 12;
	localparam int SPOKE_HI = 31; // spoke number is the top address bits
	localparam int SPOKE_LO = 29;
	localparam int LVL_FAIR_MIN = 2; // first level under fairness
	localparam int SLOT_W = 7; // fairness slot counter width
	localparam logic [2:0] BURST_BEATS = 3'h4; // beats per transaction
	localparam logic [3:0] STARVE_LIMIT = 4'h8; // cycles dma may yield
	//==========================================================================
	// register map, byte addresses
	localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] REG_PEND = 12'h008;
	localparam logic [ADDR_W-1:0] REG_CMD = 12'h00c;
	localparam logic [ADDR_W-1:0] CH_BASE = 12'h100;
	localparam logic [ADDR_W-1:0] TD_BASE = 12'h800;
	localparam int CH_IDX_LO = 2;
	localparam int CH_IDX_HI = 6;
	localparam int TD_IDX_LO = 4;
	localparam int TD_IDX_HI = 10;
	localparam int WORD_LO = 2;
	localparam int WORD_HI = 3;
	localparam logic [1:0] TD_WORD_SRC = 2'h0;
	localparam logic [1:0] TD_WORD_DST = 2'h1;
	localparam logic [1:0] TD_WORD_CTL = 2'h2;
	localparam int CTRL_FAIR_BIT = 0;
	localparam int STAT_CH_LO = 8;
	localparam logic [1:0] CMD_TRIG = 2'h1;
	localparam logic [1:0] CMD_CANCEL = 2'h2;
	localparam int CFG_W = 21;
	//==========================================================================
	// types
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOAD = 2'h1,
		ST_RUN = 2'h3,
		ST_DONE = 2'h2
	} fsm_t;
	typedef struct packed {
		logic [CH_W-1:0] chain_ch; // channel triggered at chain end
		logic chain_en;
		logic stall;
		logic rr_dis; // lowest numbered such channel heads its level
		logic en;
		logic rsvd_hi;
		logic [2:0] prio;
		logic rsvd_lo;
		logic [TD_W-1:0] first_td;
	} cfg_t;
	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic t1_en; // second interrupt at chain end
		logic t0_en; // first interrupt at descriptor end
		logic chain_end;
		logic inf; // unbounded length
		logic [1:0] size; // bytes per beat minus one
		logic rsvd_lo;
		logic [TD_W-1:0] next;
		logic [15:0] len; // bytes minus one
	} td_ctl_t;
	typedef struct packed {
		logic [21:0] rsvd_hi;
		logic [1:0] op;
		logic [2:0] rsvd_lo;
		logic [CH_W-1:0] ch;
	} cmd_t;
	typedef struct packed {
		logic [TD_W-1:0] td;
		logic [16:0] rem; // zero means reload from descriptor
		logic [15:0] off;
	} ctx_t;
endpackage : dma_hub_pkg

// ==== dma_hub_asserts.sv ====
// checker: apb timing, spoke ownership and completion pulse properties
module dma_hub_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// processor and dma spoke traffic
	input wire logic cpu_req,
	input wire logic [2:0] cpu_spoke,
	input wire logic cpu_gnt,
	input wire logic rd_req,
	input wire logic [31:0] rd_addr,
	input wire logic wr_req,
	input wire logic [31:0] wr_addr,
	// completion pulses
	input wire logic [dma_hub_pkg::NUM_CH-1:0] term0,
	input wire logic [dma_hub_pkg::NUM_CH-1:0] term1
);
	timeunit 1ns;
	timeprecision 1ps;
	//==========================================================================
	// helper: cycles since the last destination write, saturating
	logic [3:0] since_wr_ff; // parked at 15 so reset never looks recent
	logic [3:0] nxt_since_wr;
	always_comb begin
		nxt_since_wr = since_wr_ff;
		if (wr_req) begin
			nxt_since_wr = 4'h0;
		end else if (since_wr_ff != 4'hf) begin
			nxt_since_wr = since_wr_ff + 4'h1;
		end
	end
	// register the counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			since_wr_ff <= 4'hf;
		end else begin
			since_wr_ff <= nxt_since_wr;
		end
	end
	//==========================================================================
	// properties, all in the one clock domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// apb answers in the access cycle only
	pready_after_setup_a: assert property (
		psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	pready_single_a: assert property (
		pready |=> !pready)
		else $error("pready held longer than one cycle");
	slverr_with_ready_a: assert property (
		pslverr |-> pready)
		else $error("pslverr outside an access cycle");
	// one read in flight: nothing else moves two cycles after a read
	read_spacing_a: assert property (
		rd_req |=> (!rd_req && !wr_req) [*2])
		else $error("spoke access too soon after a read");
	// every read is drained into a write, even under cpu contention
	write_follows_read_a: assert property (
		rd_req |-> ##[3:16] wr_req)
		else $error("read beat never written out");
	// while the cpu owns a spoke no dma access lands on it
	cpu_owns_spoke_a: assert property (
		cpu_gnt |-> !(rd_req && rd_addr[31:29] == cpu_spoke) &&
			!(wr_req && wr_addr[31:29] == cpu_spoke))
		else $error("dma used the spoke granted to the cpu");
	cpu_gnt_cause_a: assert property (
		cpu_gnt |-> $past(cpu_req))
		else $error("cpu grant without request");
	// a cpu request is served unless the dma takes its starvation slot
	cpu_served_a: assert property (
		cpu_req |=> cpu_gnt || rd_req || wr_req)
		else $error("cpu request neither granted nor overridden");
	term_one_cycle_a: assert property (
		(term0 & $past(term0)) == '0 && (term1 & $past(term1)) == '0)
		else $error("completion pulse longer than one cycle");
	term_after_write_a: assert property (
		(|term0 || |term1) |-> since_wr_ff <= 4'h4)
		else $error("completion pulse without a recent write");
	// main scenarios
	concurrent_cv: cover property (rd_req && wr_req);
	chain_end_cv: cover property (|term1);
	starve_cv: cover property (cpu_req ##1 (cpu_req && !cpu_gnt));
endmodule : dma_hub_asserts

bind dma_hub dma_hub_asserts u_dma_hub_asserts (
	.clk(clk),
	.rst_n(rst_n),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.cpu_req(cpu_req),
	.cpu_spoke(cpu_spoke),
	.cpu_gnt(cpu_gnt),
	.rd_req(rd_req),
	.rd_addr(rd_addr),
	.wr_req(wr_req),
	.wr_addr(wr_addr),
	.term0(term0),
	.term1(term1)
);

// ==== spoke_mem_model.sv ====
// spoke side model: memory that answers dma source reads
module spoke_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// dma source read port
	input wire logic rd_req,
	input wire logic [31:0] rd_addr,
	output logic [31:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	//==========================================================================
	// contents are a fixed pattern of the address
	localparam logic [31:0] PAT = 32'h5a5a_5a5a;
	// word valid only in the cycle after a read; otherwise the bus toggles
	// so a late sample never sees a stale word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 32'h0000_0000;
		end else if (rd_req) begin
			rd_data <= rd_addr ^ PAT;
		end else begin
			rd_data <= ~rd_data;
		end
	end
endmodule : spoke_mem_model

// ==== dma_hub_tb_top.sv ====
// testbench top: apb tasks, spoke model and directed dma scenarios
module dma_hub_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	//==========================================================================
	// signals and bookkeeping
	localparam logic [31:0] PAT = 32'h5a5a_5a5a; // model memory pattern
	localparam logic [11:0] TDB = dma_hub_pkg::TD_BASE;
	localparam logic [11:0] CHB = dma_hub_pkg::CH_BASE;
	localparam logic [11:0] CMD = dma_hub_pkg::REG_CMD;
	localparam logic [11:0] PEND = dma_hub_pkg::REG_PEND;
	logic clk;
	logic rst_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [23:0] trig_in;
	logic cpu_req;
	logic [2:0] cpu_spoke;
	logic cpu_gnt;
	logic rd_req;
	logic wr_req;
	logic [31:0] rd_addr;
	logic [31:0] rd_data;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [1:0] rd_size;
	logic [1:0] wr_size;
	logic [23:0] term0;
	logic [23:0] term1;
	logic [23:0] t0_seen = '0; // sticky completion bits per channel
	logic [23:0] t1_seen = '0;
	logic [31:0] wa_q[$]; // destination writes in order
	logic [31:0] wd_q[$];
	int gnt_n = 0;
	int errors = 0;
	int checks_done = 0;
	//==========================================================================
	// design and spoke model
	dma_hub u_dma_hub (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trig_in(trig_in), .cpu_req(cpu_req), .cpu_spoke(cpu_spoke),
		.cpu_gnt(cpu_gnt), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_size(rd_size), .rd_data(rd_data), .wr_req(wr_req),
		.wr_addr(wr_addr), .wr_size(wr_size), .wr_data(wr_data),
		.term0(term0), .term1(term1));
	spoke_mem_model u_spoke_mem_model (.clk(clk), .rst_n(rst_n),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data));
	// 40 mhz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// monitor of destination writes, completions and cpu grants
	always @(posedge clk) begin
		if (rst_n === 1'b1) begin
			if (rd_req === 1'b1) chk("rd size", 32'(rd_size), 32'h0000_0003);
			if (wr_req === 1'b1) begin
				chk("wr size", 32'(wr_size), 32'h0000_0003);
				wa_q.push_back(wr_addr);
				wd_q.push_back(wr_data);
			end
			t0_seen <= t0_seen | term0;
			t1_seen <= t1_seen | term1;
			if (cpu_gnt === 1'b1) gnt_n++;
		end
	end
	//==========================================================================
	// tasks
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one apb transfer; the request stands until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		// a slave that never answers counts against the run
		if (pready !== 1'b1) errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd_chk(input string what, input logic [11:0] a,
		input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		chk(what, q, exp);
	endtask : rd_chk
	// bounded waits on the monitor, never on a guessed latency
	task automatic wait_t1(input int ch);
		int n;
		n = 0;
		while (t1_seen[ch] !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (t1_seen[ch] !== 1'b1) errors++;
	endtask : wait_t1
	task automatic wait_wq(input int k);
		int n;
		n = 0;
		while (wa_q.size() < k && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (wa_q.size() < k) errors++;
	endtask : wait_wq
	task automatic stop_test();
		if (errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		stop_test();
	end
	//==========================================================================
	// scenarios
	initial begin
		logic [31:0] q;
		logic e;
		int b;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		trig_in = 24'h00_0000;
		cpu_req = 1'b0;
		cpu_spoke = 3'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		// reset state and an unmapped place
		rd_chk("ctrl", dma_hub_pkg::REG_CTRL, 32'h0000_0000);
		rd_chk("pend", PEND, 32'h0000_0000);
		rd_chk("status", dma_hub_pkg::REG_STATUS, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0000_0000, q, e);
		chk("unmapped err", 32'(e), 32'h0000_0001);
		chk("unmapped data", q, 32'h0000_0000);
		// every priority level is held per channel (disabled channels)
		for (int p = 0; p < 8; p++) begin
			wr(CHB + 12'(4 * (4 + p)), 32'(p) << 8);
			rd_chk("prio", CHB + 12'(4 * (4 + p)), 32'(p) << 8);
		end
		// simple transfer, 8 bytes in 4-byte beats, processor trigger
		wr(TDB, 32'h0000_0100);
		wr(TDB + 12'h004, 32'h2000_0200);
		wr(TDB + 12'h008, 32'h3b00_0007);
		rd_chk("td ctl", TDB + 12'h008, 32'h3b00_0007);
		rd_chk("td pad", TDB + 12'h00c, 32'h0000_0000);
		wr(CHB, 32'h0000_1000);
		wr(CMD, 32'h0000_0100);
		wait_t1(0);
		chk("beats", 32'(wa_q.size()), 32'h0000_0002);
		chk("addr0", wa_q[0], 32'h2000_0200);
		chk("addr1", wa_q[1], 32'h2000_0204);
		chk("data0", wd_q[0], 32'h0000_0100 ^ PAT);
		chk("data1", wd_q[1], 32'h0000_0104 ^ PAT);
		chk("term0", 32'(t0_seen[0]), 32'h0000_0001);
		chk("term1", 32'(t1_seen[0]), 32'h0000_0001);
		rd_chk("pend done", PEND, 32'h0000_0000);
		// routed trigger while the cpu keeps the source spoke busy
		cpu_req <= 1'b1;
		wr(TDB + 12'h010, 32'h0000_0300);
		wr(TDB + 12'h014, 32'h4000_0000);
		wr(TDB + 12'h018, 32'h2b01_0003);
		wr(CHB + 12'h004, 32'h0000_1001);
		trig_in <= 24'h00_0002;
		@(posedge clk);
		trig_in <= 24'h00_0000;
		wait_t1(1);
		chk("starved done", 32'(t1_seen[1]), 32'h0000_0001);
		chk("trig addr", wa_q[2], 32'h4000_0000);
		chk("trig data", wd_q[2], 32'h0000_0300 ^ PAT);
		chk("cpu first", 32'(gnt_n > 0), 32'h0000_0001);
		cpu_req <= 1'b0;
		// prio 5 and prio 1 raised together, fairness off
		wr(TDB + 12'h020, 32'h0000_0100);
		wr(TDB + 12'h024, 32'h6000_0000);
		wr(TDB + 12'h028, 32'h2b02_0003);
		wr(TDB + 12'h030, 32'h0000_0100);
		wr(TDB + 12'h034, 32'h8000_0000);
		wr(TDB + 12'h038, 32'h2b03_0003);
		wr(CHB + 12'h008, 32'h0000_1502);
		wr(CHB + 12'h00c, 32'h0000_1103);
		b = wa_q.size();
		trig_in <= 24'h00_000c;
		@(posedge clk);
		trig_in <= 24'h00_0000;
		wait_t1(2);
		wait_t1(3);
		chk("prio1 first", wa_q[b], 32'h8000_0000);
		chk("prio5 next", wa_q[b + 1], 32'h6000_0000);
		// ping pong pair under fairness, then cancelled
		wr(dma_hub_pkg::REG_CTRL, 32'h0000_0001);
		rd_chk("fair on", dma_hub_pkg::REG_CTRL, 32'h0000_0001);
		wr(TDB + 12'h040, 32'h0000_0100);
		wr(TDB + 12'h044, 32'ha000_0000);
		wr(TDB + 12'h048, 32'h1305_0003);
		wr(TDB + 12'h050, 32'h0000_0100);
		wr(TDB + 12'h054, 32'ha000_0100);
		wr(TDB + 12'h058, 32'h1304_0003);
		wr(CHB + 12'h030, 32'h0000_1204);
		b = wa_q.size();
		wr(CMD, 32'h0000_010c);
		wait_wq(b + 3);
		chk("ping", wa_q[b], 32'ha000_0000);
		chk("pong", wa_q[b + 1], 32'ha000_0100);
		chk("ping again", wa_q[b + 2], 32'ha000_0000);
		chk("td done", 32'(t0_seen[12]), 32'h0000_0001);
		wr(CMD, 32'h0000_020c);
		repeat (40) @(posedge clk);
		b = wa_q.size();
		repeat (40) @(posedge clk);
		chk("cancel stops", 32'(wa_q.size()), 32'(b));
		rd_chk("pend cancel", PEND, 32'h0000_0000);
		stop_test();
	end
endmodule : dma_hub_tb_top
